/* src/ewfs_pkg.sv */
package ewfs_pkg;
   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam logic [15:0] EWFS_ADDR_LINE_CNT = 16'hA97C;
   localparam logic [15:0] EWFS_ADDR_R_SLOPE = 16'hAD68;
   localparam logic [15:0] EWFS_ADDR_R_ORIGIN = 16'hAD6C;
   localparam logic [15:0] EWFS_ADDR_L_SLOPE = 16'hAD70;
   localparam logic [15:0] EWFS_ADDR_L_ORIGIN = 16'hAD74;
   localparam logic [15:0] EWFS_ADDR_FIRST_Y = 16'hAD78;
   localparam logic [15:0] EWFS_ADDR_POLY_CNT = 16'hAD7C;
   localparam logic [15:0] EWFS_ADDR_STATUS = 16'hAD80;
   localparam logic [15:0] EWFS_ADDR_R_POS = 16'hAD84;
   localparam logic [15:0] EWFS_ADDR_L_POS = 16'hAD88;
   localparam logic [15:0] EWFS_ADDR_CUR_Y = 16'hAD8C;
   // ---------------------------------------------------------------
   // field positions and widths
   // ---------------------------------------------------------------
   localparam int EWFS_CNT_W = 11;
   localparam int EWFS_DIR_BIT = 31;
   localparam int EWFS_RELOAD_R_BIT = 28;
   localparam int EWFS_RELOAD_L_BIT = 29;
   localparam int EWFS_FRAC_W = 20;
   localparam logic [31:0] EWFS_LINE_CNT_MASK = 32'h800007FF;
   localparam logic [31:0] EWFS_POLY_CNT_MASK = 32'h300007FF;
   localparam logic [31:0] EWFS_CNT_MASK = 32'h000007FF;
   localparam logic [31:0] EWFS_RESET_WORD = 32'h00000000;
   localparam logic [1:0] EWFS_RESP_OKAY = 2'h0;
   localparam logic [1:0] EWFS_RESP_SLVERR = 2'h2;
   typedef enum logic [0:0] {
      EWFS_IDLE = 1'b0,
      EWFS_WALK = 1'b1
   } ewfs_state_e;
endpackage : ewfs_pkg

/* src/ewfs_edge.sv */
`timescale 1ns/1ns
// one polygon edge: reload on command, then add slope per scanline
module ewfs_edge
   import ewfs_pkg::*;
#(
   parameter int W = 32
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic reload,
   input wire logic step,
   input wire logic [W-1:0] slope,
   input wire logic [W-1:0] origin,
   // accumulated position, signed 11.20
   output logic signed [W-1:0] pos_q
);
   logic signed [W-1:0] pos_d;
   // reload wins over a step in the same cycle
   assign pos_d = reload ? $signed(origin) : (step ? pos_q + $signed(slope) : pos_q);
   // position register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pos_q <= '0;
      end else begin
         pos_q <= pos_d;
      end
   end
endmodule : ewfs_edge

/* src/ewfs_axil.sv */
`timescale 1ns/1ns
// axi4-lite slave front end: one write and one read at a time
module ewfs_axil
   import ewfs_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write channels
   input wire logic [15:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // read channels
   input wire logic [15:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // register side
   output logic wr_en,
   output logic [15:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_err,
   output logic [15:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   logic aw_have_q;
   logic w_have_q;
   logic [15:0] aw_q;
   logic [31:0] w_q;
   logic [3:0] s_q;
   wire aw_take = awvalid && awready;
   wire w_take = wvalid && wready;
   wire ar_take = arvalid && arready;
   // address and data held until both are in and the response has gone
   assign awready = !aw_have_q && !bvalid;
   assign wready = !w_have_q && !bvalid;
   assign wr_en = aw_have_q && w_have_q && !bvalid;
   assign wr_addr = aw_q;
   assign wr_data = w_q;
   assign wr_strb = s_q;
   assign arready = !rvalid;
   assign rd_addr = araddr;
   // write side
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_q <= '0;
         w_q <= '0;
         s_q <= '0;
         bvalid <= 1'b0;
         bresp <= EWFS_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_have_q <= 1'b1;
            aw_q <= {awaddr[15:2], 2'b00};
         end
         if (w_take) begin
            w_have_q <= 1'b1;
            w_q <= wdata;
            s_q <= wstrb;
         end
         if (wr_en) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_err ? EWFS_RESP_SLVERR : EWFS_RESP_OKAY;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end
   // read side, data registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= EWFS_RESP_OKAY;
      end else if (ar_take) begin
         rvalid <= 1'b1;
         rdata <= rd_err ? EWFS_RESET_WORD : rd_data;
         rresp <= rd_err ? EWFS_RESP_SLVERR : EWFS_RESP_OKAY;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule : ewfs_axil

/* src/ewfs_top.sv */
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
// Behaviour
// - direction bit 0 right-left, 1 left-right
// - slopes and origins are signed 11.20
// - x-major many pixels, y-major one per scanline; no line walker here, only the direction bit is passed on
// - fill starts at first scanline, steps upward
// - reload right on bit 28, left on 29
// - setup registers need no initial value
// - lines always walk bottom to top; no line walker here, lines are not drawn
module ewfs_top
   import ewfs_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // scanline walk to the pixel engine
   output logic span_valid,
   output logic [EWFS_CNT_W-1:0] span_y,
   output logic [31:0] span_left_x,
   output logic [31:0] span_right_x,
   output logic line_left_to_right,
   output logic fill_busy
);
   // ---------------------------------------------------------------
   // bus front end
   // ---------------------------------------------------------------
   // register-side strobes
   logic wr_en;
   logic [15:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_err;
   logic [15:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_err;
   // a write lands one cycle after both halves are in
   ewfs_axil u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(wr_err),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );
   // ---------------------------------------------------------------
   // setup registers
   // ---------------------------------------------------------------
   // one word per setup register; the walk reads them
   // live, so do not rewrite a slope mid-walk
   logic [31:0] line_cnt_q;
   logic [31:0] r_slope_q;
   logic [31:0] r_origin_q;
   logic [31:0] l_slope_q;
   logic [31:0] l_origin_q;
   logic [31:0] first_y_q;
   logic [31:0] poly_cnt_q;
   logic [31:0] bytemask;
   // byte-lane merge with the write strobes
   assign bytemask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   // reserved bits are forced to zero by the keep mask
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [31:0] bm, input logic [31:0] keep);
      merge = ((old & ~bm) | (nw & bm)) & keep;
   endfunction : merge
   // ---------------------------------------------------------------
   // write decode
   // ---------------------------------------------------------------
   // one strobe per writable register
   wire hit_line = wr_en && (wr_addr == EWFS_ADDR_LINE_CNT);
   wire hit_rs = wr_en && (wr_addr == EWFS_ADDR_R_SLOPE);
   wire hit_ro = wr_en && (wr_addr == EWFS_ADDR_R_ORIGIN);
   wire hit_ls = wr_en && (wr_addr == EWFS_ADDR_L_SLOPE);
   wire hit_lo = wr_en && (wr_addr == EWFS_ADDR_L_ORIGIN);
   wire hit_fy = wr_en && (wr_addr == EWFS_ADDR_FIRST_Y);
   wire hit_pc = wr_en && (wr_addr == EWFS_ADDR_POLY_CNT);
   // read-only words: accepted with okay, dropped
   wire hit_ro_regs = (wr_addr == EWFS_ADDR_STATUS) || (wr_addr == EWFS_ADDR_R_POS) ||
                      (wr_addr == EWFS_ADDR_L_POS) || (wr_addr == EWFS_ADDR_CUR_Y);
   // unmapped writes answer with slave error
   assign wr_err = !(hit_line || hit_rs || hit_ro || hit_ls || hit_lo || hit_fy || hit_pc ||
                     hit_ro_regs);
   // register storage; cleared at reset for determinism only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_cnt_q <= EWFS_RESET_WORD;
         r_slope_q <= EWFS_RESET_WORD;
         r_origin_q <= EWFS_RESET_WORD;
         l_slope_q <= EWFS_RESET_WORD;
         l_origin_q <= EWFS_RESET_WORD;
         first_y_q <= EWFS_RESET_WORD;
         poly_cnt_q <= EWFS_RESET_WORD;
      end else begin
         // a partial strobe merges into the old word
         if (hit_line) line_cnt_q <= merge(line_cnt_q, wr_data, bytemask, EWFS_LINE_CNT_MASK);
         if (hit_rs) r_slope_q <= merge(r_slope_q, wr_data, bytemask, '1);
         if (hit_ro) r_origin_q <= merge(r_origin_q, wr_data, bytemask, '1);
         if (hit_ls) l_slope_q <= merge(l_slope_q, wr_data, bytemask, '1);
         if (hit_lo) l_origin_q <= merge(l_origin_q, wr_data, bytemask, '1);
         if (hit_fy) first_y_q <= merge(first_y_q, wr_data, bytemask, EWFS_CNT_MASK);
         if (hit_pc) poly_cnt_q <= merge(poly_cnt_q, wr_data, bytemask, EWFS_POLY_CNT_MASK);
      end
   end
   // no line walker here; the bit is only passed on
   // direction flag reaches the pixel engine directly
   assign line_left_to_right = line_cnt_q[EWFS_DIR_BIT];
   // ---------------------------------------------------------------
   // fill walk
   // ---------------------------------------------------------------
   // a nonzero count written while idle starts a walk;
   // a write while busy only updates the register and
   // does not restart, so software polls status first
   // walk state, remaining count, current scanline
   ewfs_state_e state_q;
   ewfs_state_e state_d;
   logic [EWFS_CNT_W-1:0] remain_q;
   logic [EWFS_CNT_W-1:0] remain_d;
   logic [EWFS_CNT_W-1:0] y_q;
   logic [EWFS_CNT_W-1:0] y_d;
   logic started_q;
   logic [EWFS_CNT_W-1:0] new_cnt;
   // the count word as it stands after this write
   wire [31:0] pc_next = merge(poly_cnt_q, wr_data, bytemask, EWFS_POLY_CNT_MASK);
   assign new_cnt = pc_next[EWFS_CNT_W-1:0];
   // a zero count is refused: no walk
   wire start = hit_pc && (new_cnt != '0);
   wire reload_right_edge = start && pc_next[EWFS_RELOAD_R_BIT];
   wire reload_left_edge = start && pc_next[EWFS_RELOAD_L_BIT];
   // one scanline per clock while walking
   wire step = (state_q == EWFS_WALK);
   // last scanline of this update
   wire last = step && (remain_q == 11'h001);
   // next-state, count and scanline
   always_comb begin
      // hold unless a branch below moves it
      state_d = state_q;
      remain_d = remain_q;
      y_d = y_q;
      unique case (state_q)
         EWFS_IDLE: begin
            // only an idle engine accepts a start
            if (start) begin
               state_d = EWFS_WALK;
               remain_d = new_cnt;
               // first update of a polygon begins at the programmed scanline
               if (!started_q || (pc_next[EWFS_RELOAD_R_BIT] && pc_next[EWFS_RELOAD_L_BIT])) begin
                  y_d = first_y_q[EWFS_CNT_W-1:0];
               end
            end
         end
         EWFS_WALK: begin
            // a larger y is further down, so up is minus one
            remain_d = remain_q - 11'h001;
            y_d = y_q - 11'h001;
            if (last) state_d = EWFS_IDLE;
         end
      endcase
   end
   // all walk state moves together on one edge
   // walk state registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= EWFS_IDLE;
         remain_q <= '0;
         y_q <= '0;
         started_q <= 1'b0;
      end else begin
         state_q <= state_d;
         remain_q <= remain_d;
         y_q <= y_d;
         // later updates continue from the current y
         if (start) started_q <= 1'b1;
      end
   end
   // two edges, each reloads only when its bit is set
   // reloads are gated by idle so a write during
   // a walk cannot jerk an edge mid-polygon
   // positions are signed 11.20, as programmed
   logic signed [31:0] r_pos;
   logic signed [31:0] l_pos;
   ewfs_edge u_right (
      .aclk(aclk),
      .aresetn(aresetn),
      .reload(reload_right_edge && (state_q == EWFS_IDLE)),
      .step(step),
      .slope(r_slope_q),
      .origin(r_origin_q),
      .pos_q(r_pos)
   );
   ewfs_edge u_left (
      .aclk(aclk),
      .aresetn(aresetn),
      .reload(reload_left_edge && (state_q == EWFS_IDLE)),
      .step(step),
      .slope(l_slope_q),
      .origin(l_origin_q),
      .pos_q(l_pos)
   );
   // ---------------------------------------------------------------
   // span output
   // ---------------------------------------------------------------
   // a span trails its step by one cycle and
   // holds the positions from before the step
   // span output registered, one per scanline
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         span_valid <= 1'b0;
         span_y <= '0;
         span_left_x <= '0;
         span_right_x <= '0;
      end else begin
         span_valid <= step;
         span_y <= y_q;
         span_left_x <= l_pos;
         span_right_x <= r_pos;
      end
   end
   // busy is a decode of the state register
   assign fill_busy = step;
   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   // read address decode, one wire per register
   wire rd_line = (rd_addr == EWFS_ADDR_LINE_CNT);
   wire rd_rs = (rd_addr == EWFS_ADDR_R_SLOPE);
   wire rd_ro = (rd_addr == EWFS_ADDR_R_ORIGIN);
   wire rd_ls = (rd_addr == EWFS_ADDR_L_SLOPE);
   wire rd_lo = (rd_addr == EWFS_ADDR_L_ORIGIN);
   wire rd_fy = (rd_addr == EWFS_ADDR_FIRST_Y);
   wire rd_pc = (rd_addr == EWFS_ADDR_POLY_CNT);
   wire rd_st = (rd_addr == EWFS_ADDR_STATUS);
   wire rd_rp = (rd_addr == EWFS_ADDR_R_POS);
   wire rd_lp = (rd_addr == EWFS_ADDR_L_POS);
   wire rd_cy = (rd_addr == EWFS_ADDR_CUR_Y);
   // live walk state, read only; bit 0 is busy
   wire [31:0] status_word = {31'h00000000, step};
   wire [31:0] cur_y_word = {21'h000000, y_q};
   // read data select; unmapped reads return zero with an error
   assign rd_data = rd_line ? line_cnt_q :
                    rd_rs ? r_slope_q :
                    rd_ro ? r_origin_q :
                    rd_ls ? l_slope_q :
                    rd_lo ? l_origin_q :
                    rd_fy ? first_y_q :
                    rd_pc ? poly_cnt_q :
                    rd_st ? status_word :
                    rd_rp ? r_pos :
                    rd_lp ? l_pos :
                    rd_cy ? cur_y_word : EWFS_RESET_WORD;
   assign rd_err = !(rd_line || rd_rs || rd_ro || rd_ls || rd_lo || rd_fy || rd_pc ||
                     rd_st || rd_rp || rd_lp || rd_cy);
endmodule : ewfs_top

/* sim/ewfs_top_properties.sv */
`timescale 1ns/1ns
// watches the bus handshakes and the scanline walk at the top ports
module ewfs_top_properties
   import ewfs_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // scanline walk
   input wire logic span_valid,
   input wire logic [EWFS_CNT_W-1:0] span_y,
   input wire logic [31:0] span_left_x,
   input wire logic [31:0] span_right_x,
   input wire logic line_left_to_right,
   input wire logic fill_busy
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // address and data taken at one edge
   wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire poly_wr = wr_take && (s_axi_awaddr == EWFS_ADDR_POLY_CNT) && (s_axi_wstrb == 4'hF);
   // ---------------------------------------------------------------
   // sequences and properties
   // ---------------------------------------------------------------
   sequence s_dir_wr;
      wr_take && (s_axi_awaddr == EWFS_ADDR_LINE_CNT) && s_axi_wstrb[3];
   endsequence
   sequence s_start_wr;
      poly_wr && (s_axi_wdata[10:0] != 11'h000) && !fill_busy;
   endsequence
   sequence s_three_spans;
      span_valid ##1 span_valid ##1 span_valid;
   endsequence
   property p_b_answer;
      wr_take |-> ##2 s_axi_bvalid;
   endproperty
   property p_b_stand;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   property p_r_stand;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_dir;
      s_dir_wr |-> ##2 (line_left_to_right == $past(s_axi_wdata[31], 2));
   endproperty
   property p_fill_start;
      s_start_wr |-> ##[1:3] fill_busy;
   endproperty
   property p_no_start;
      poly_wr && (s_axi_wdata[10:0] == 11'h000) && !fill_busy |-> ##1 !fill_busy [*3];
   endproperty
   property p_span_busy;
      span_valid |-> $past(fill_busy);
   endproperty
   property p_y_up;
      span_valid && $past(span_valid) |-> span_y == $past(span_y) - 11'h001;
   endproperty
   property p_x_linear;
      s_three_spans |-> (span_left_x - $past(span_left_x)) ==
         ($past(span_left_x) - $past(span_left_x, 2)) &&
         (span_right_x - $past(span_right_x)) == ($past(span_right_x) - $past(span_right_x, 2));
   endproperty
   property p_walk_end;
      $fell(fill_busy) |-> span_valid ##1 !span_valid;
   endproperty
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_b_answer: assert property (p_b_answer) else $error("write response late");
   a_b_stand: assert property (p_b_stand) else $error("write response dropped");
   a_r_answer: assert property (p_r_answer) else $error("read data late");
   a_r_stand: assert property (p_r_stand) else $error("read data dropped");
   a_dir: assert property (p_dir) else $error("direction bit wrong");
   a_fill_start: assert property (p_fill_start) else $error("fill not started");
   a_no_start: assert property (p_no_start) else $error("fill on zero count");
   a_span_busy: assert property (p_span_busy) else $error("span outside walk");
   a_y_up: assert property (p_y_up) else $error("scanline not stepped up");
   a_x_linear: assert property (p_x_linear) else $error("edge step not constant");
   a_walk_end: assert property (p_walk_end) else $error("walk end wrong");
endmodule : ewfs_top_properties

bind ewfs_top ewfs_top_properties u_ewfs_top_properties (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .span_valid, .span_y, .span_left_x, .span_right_x,
   .line_left_to_right, .fill_busy);

/* sim/ewfs_top_tb.sv */
`timescale 1ns/1ns
// register access and polygon walk tests over the bus
module ewfs_top_tb
   import ewfs_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
   logic [31:0] wdata = 32'h00000000, rdata, span_left_x, span_right_x;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, span_valid, line_left_to_right, fill_busy;
   logic [1:0] bresp, rresp, r;
   logic [10:0] span_y;
   logic [10:0] qy[$];
   logic [31:0] ql[$], qr[$], d, wd;
   int n_mismatch = 0, total_checks = 0;
   ewfs_top u_ewfs_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .span_valid(span_valid), .span_y(span_y), .span_left_x(span_left_x),
      .span_right_x(span_right_x), .line_left_to_right(line_left_to_right),
      .fill_busy(fill_busy));
   // 100 MHz clock
   initial begin
      forever #5 aclk = ~aclk;
   end
   // collect every span the walk emits
   always @(negedge aclk) begin
      if (span_valid === 1'b1) begin
         qy.push_back(span_y);
         ql.push_back(span_left_x);
         qr.push_back(span_right_x);
      end
   end
   // ---------------------------------------------------------------
   // bus tasks and checks
   // ---------------------------------------------------------------
   task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic [3:0] s);
      logic aw_t, w_t;
      aw_t = 1'b0;
      w_t = 1'b0;
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1; // ready stands from the request on
      while (!(aw_t && w_t)) begin
         @(negedge aclk);
         aw_t = aw_t || awready;
         w_t = w_t || wready;
         @(posedge aclk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [15:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge aclk);
   endtask : rd
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // start an update and compare every span against the edge arithmetic
   task automatic fill(input logic [31:0] v, input logic [10:0] y0, input logic [31:0] l0,
                       input logic [31:0] ls, input logic [31:0] r0, input logic [31:0] rs);
      int n;
      n = int'(v[10:0]);
      qy.delete();
      ql.delete();
      qr.delete();
      wr(EWFS_ADDR_POLY_CNT, v, 4'hF);
      repeat (n + 6) @(posedge aclk);
      chk(32'(qy.size()), 32'(n));
      for (int i = 0; i < n; i++) begin
         chk(32'(qy[i]), 32'(y0) - 32'(i));
         chk(ql[i], l0 + 32'(i) * ls);
         chk(qr[i], r0 + 32'(i) * rs);
      end
      chk(32'(fill_busy), 32'h00000000);
   endtask : fill
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      logic [15:0] ra [8];
      logic [31:0] rm [8];
      ra = '{EWFS_ADDR_LINE_CNT, EWFS_ADDR_R_SLOPE, EWFS_ADDR_R_ORIGIN, EWFS_ADDR_L_SLOPE,
             EWFS_ADDR_L_ORIGIN, EWFS_ADDR_FIRST_Y, EWFS_ADDR_POLY_CNT, EWFS_ADDR_STATUS};
      rm = '{EWFS_LINE_CNT_MASK, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
             EWFS_CNT_MASK, EWFS_POLY_CNT_MASK, 32'h00000000};
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
         wd = (i == 6) ? 32'hFFFFF800 : 32'hFFFFFFFF;
         wr(ra[i], wd, 4'hF);
         chk(32'(r), 32'(EWFS_RESP_OKAY));
         rd(ra[i]);
         chk(d, wd & rm[i]);
         chk(32'(fill_busy), 32'h00000000);
      end
      chk(32'(line_left_to_right), 32'h00000001);
      wr(EWFS_ADDR_LINE_CNT, 32'h00000005, 4'hF);
      chk(32'(line_left_to_right), 32'h00000000);
      wr(16'hA000, 32'hFFFFFFFF, 4'hF);
      chk(32'(r), 32'(EWFS_RESP_SLVERR));
      rd(16'hA000);
      chk(d, 32'h00000000);
      chk(32'(r), 32'(EWFS_RESP_SLVERR));
      wr(EWFS_ADDR_R_SLOPE, 32'h00000000, 4'hF);
      wr(EWFS_ADDR_R_SLOPE, 32'hFFFFFFFF, 4'h1);
      rd(EWFS_ADDR_R_SLOPE);
      chk(d, 32'h000000FF);
      // right edge +0.5 per line, left edge -1.0 per line
      wr(EWFS_ADDR_FIRST_Y, 32'h00000064, 4'hF);
      wr(EWFS_ADDR_R_SLOPE, 32'h00080000, 4'hF);
      wr(EWFS_ADDR_R_ORIGIN, 32'h06480000, 4'hF);
      wr(EWFS_ADDR_L_SLOPE, 32'hFFF00000, 4'hF);
      wr(EWFS_ADDR_L_ORIGIN, 32'h03280000, 4'hF);
      fill(32'h30000003, 11'd100, 32'h03280000, 32'hFFF00000,
           32'h06480000, 32'h00080000);
      wr(EWFS_ADDR_L_SLOPE, 32'h00200000, 4'hF);
      wr(EWFS_ADDR_L_ORIGIN, 32'h03C80000, 4'hF);
      fill(32'h20000002, 11'd97, 32'h03C80000, 32'h00200000, 32'h06600000, 32'h00080000);
      wr(EWFS_ADDR_R_ORIGIN, 32'h07080000, 4'hF);
      fill(32'h10000001, 11'd95, 32'h04080000, 32'h00200000, 32'h07080000, 32'h00080000);
      // positions and scanline after the last step
      rd(EWFS_ADDR_R_POS);
      chk(d, 32'h07100000);
      rd(EWFS_ADDR_L_POS);
      chk(d, 32'h04280000);
      rd(EWFS_ADDR_CUR_Y);
      chk(d, 32'h0000005E);
      test_done;
   end
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      test_done;
   end
endmodule : ewfs_top_tb
